/* File: shared/cobc_pkg.sv */
// Purpose: shared constants and types for the clock output bank configuration block
// Assumes: byte-wide register port fed by the serial programming front end
// Notes:   offsets are the device byte addresses of the bank
`default_nettype none
package cobc_pkg;
  localparam int unsigned COBC_NUM_REGS = 8;
  // register byte addresses
  localparam logic [7:0] COBC_OFS_BASE          = 8'h58;
  localparam logic [7:0] COBC_OFS_OUTPUT_PAIR_FIVE_CONTROL  = 8'h58;
  localparam logic [7:0] COBC_OFS_OUTPUT_PAIR_FIVE_LOWMODE  = 8'h59;
  localparam logic [7:0] COBC_OFS_OUTPUT_PAIR_FIVE_HIGH0    = 8'h5A;
  localparam logic [7:0] COBC_OFS_OUTPUT_PAIR_FIVE_HIGH1    = 8'h5B;
  localparam logic [7:0] COBC_OFS_OUTPUT_SIX_CONTROL  = 8'h5C;
  localparam logic [7:0] COBC_OFS_OUTPUT_SIX_LOWMODE  = 8'h5D;
  localparam logic [7:0] COBC_OFS_OUTPUT_SIX_HIGH0    = 8'h5E;
  localparam logic [7:0] COBC_OFS_OUTPUT_SIX_HIGH1    = 8'h5F;
  localparam logic [7:0] COBC_OFS_LAST          = 8'h5F;
  // register indices inside the bank
  localparam int unsigned COBC_IX_CTRL  = 0;
  localparam int unsigned COBC_IX_LOW   = 1;
  localparam int unsigned COBC_IX_HIGH0 = 2;
  localparam int unsigned COBC_IX_HIGH1 = 3;
  localparam int unsigned COBC_IX_OUTPUT_SIX  = 4;
  // reset values, index order from COBC_OFS_BASE
  localparam logic [7:0] COBC_RST_OUTPUT_PAIR_FIVE_CONTROL = 8'h0C;
  localparam logic [7:0] COBC_RST_LOWMODE      = 8'hBB;
  localparam logic [7:0] COBC_RST_HIGH         = 8'h00;
  localparam logic [7:0] COBC_RST_OUTPUT_SIX_CONTROL = 8'h03;
  localparam logic [7:0] COBC_RST_UNMAPPED     = 8'h00;
  // control register fields
  localparam int unsigned COBC_F_OFF_HI   = 7;
  localparam int unsigned COBC_F_OFF_LO   = 6;
  localparam int unsigned COBC_F_EDGE_HI  = 5;
  localparam int unsigned COBC_F_EDGE_LO  = 4;
  localparam int unsigned COBC_F_INVERT   = 2;
  localparam int unsigned COBC_F_IOSTD_HI = 1;
  localparam int unsigned COBC_F_IOSTD_LO = 0;
  // low/mode register fields
  localparam int unsigned COBC_F_DIV1_HI  = 7;
  localparam int unsigned COBC_F_DIV1_LO  = 6;
  localparam int unsigned COBC_F_MODE1_HI = 5;
  localparam int unsigned COBC_F_MODE1_LO = 4;
  localparam int unsigned COBC_F_DIV0_HI  = 3;
  localparam int unsigned COBC_F_DIV0_LO  = 2;
  localparam int unsigned COBC_F_MODE0_HI = 1;
  localparam int unsigned COBC_F_MODE0_LO = 0;
  // codes
  localparam logic [1:0] COBC_MODE_DISABLED = 2'h0;
  localparam logic [1:0] COBC_OFF_PARK_LOW  = 2'h2;
  localparam logic [1:0] COBC_OFF_PARK_HIGH = 2'h3;
  localparam logic [1:0] COBC_EDGE_FASTEST  = 2'h0;
  localparam logic [1:0] COBC_IOSTD_LVTTL   = 2'h0;
  localparam logic [1:0] COBC_IOSTD_LVDS    = 2'h1;
  localparam logic [1:0] COBC_IOSTD_LVPECL  = 2'h2;
  localparam logic [9:0] COBC_DIV_DEFAULT   = 10'h002;

  // settings presented to one output's pad and divider
  typedef struct packed {
    logic       divider_on;  // divide mode of active set non-zero
    logic [1:0] div_mode;
    logic [9:0] div_value;
    logic [1:0] edge_rate;   // 00 2.75, 01 2, 10 1.25, 11 0.7 V/ns
    logic [1:0] io_std;      // 00 lvttl, 01 lvds, 10 lvpecl
    logic       invert;
    logic       drive_en;    // pad driven
    logic       drive_level; // level while parked
    logic       running;     // clock passes to the pad
  } cobc_out_t;
endpackage
`default_nettype wire

/* File: src/cobc_out_decode.sv */
// Purpose: turns one output's register bytes into registered pad and divider settings
// Assumes: control, low/mode and two high bytes come straight from the bank
// Notes:   HAS_IO_STD is zero for a single-ended output
`default_nettype none
module cobc_out_decode #(
  parameter bit HAS_IO_STD = 1'b1,
  parameter bit HAS_INVERT = 1'b0
) (
  input  wire logic            clk_i,
  input  wire logic            sys_rst_i,
  input  wire logic [7:0]      ctrl_i,
  input  wire logic [7:0]      lowmode_i,
  input  wire logic [7:0]      high0_i,
  input  wire logic [7:0]      high1_i,
  input  wire logic            use_set_one_i,
  input  wire logic            enable_bit_i,
  input  wire logic            shutdown_oe_pin_i,
  output cobc_pkg::cobc_out_t  cfg_o
);
  cobc_pkg::cobc_out_t cfg_next;
  logic [1:0]          mode_sel;
  logic [1:0]          off_sel;

  always_comb begin
    cfg_next = '0;
    // each set keeps its own high byte and low bits
    if (use_set_one_i) begin
      mode_sel           = lowmode_i[cobc_pkg::COBC_F_MODE1_HI:cobc_pkg::COBC_F_MODE1_LO];
      cfg_next.div_value = {high1_i,
                            lowmode_i[cobc_pkg::COBC_F_DIV1_HI:cobc_pkg::COBC_F_DIV1_LO]};
    end else begin
      mode_sel           = lowmode_i[cobc_pkg::COBC_F_MODE0_HI:cobc_pkg::COBC_F_MODE0_LO];
      cfg_next.div_value = {high0_i,
                            lowmode_i[cobc_pkg::COBC_F_DIV0_HI:cobc_pkg::COBC_F_DIV0_LO]};
    end
    cfg_next.div_mode   = mode_sel;
    cfg_next.divider_on = (mode_sel != cobc_pkg::COBC_MODE_DISABLED);
    cfg_next.edge_rate  = ctrl_i[cobc_pkg::COBC_F_EDGE_HI:cobc_pkg::COBC_F_EDGE_LO];
    cfg_next.io_std     = HAS_IO_STD ?
                          ctrl_i[cobc_pkg::COBC_F_IOSTD_HI:cobc_pkg::COBC_F_IOSTD_LO] :
                          cobc_pkg::COBC_IOSTD_LVTTL;
    cfg_next.invert     = HAS_INVERT & ctrl_i[cobc_pkg::COBC_F_INVERT];
    cfg_next.running    = cfg_next.divider_on & enable_bit_i & shutdown_oe_pin_i;
    off_sel             = ctrl_i[cobc_pkg::COBC_F_OFF_HI:cobc_pkg::COBC_F_OFF_LO];
    // a stopped output floats unless a park level is chosen
    if (cfg_next.running) begin
      cfg_next.drive_en    = 1'b1;
      cfg_next.drive_level = 1'b0;
    end else begin
      cfg_next.drive_en    = (off_sel == cobc_pkg::COBC_OFF_PARK_LOW) ||
                             (off_sel == cobc_pkg::COBC_OFF_PARK_HIGH);
      cfg_next.drive_level = (off_sel == cobc_pkg::COBC_OFF_PARK_HIGH);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o <= cfg_next;
    end
  end
endmodule
`default_nettype wire

/* File: src/cobc_bank.sv */
// Purpose: register bank for output pair five and output six settings
// Assumes: byte port driven by the serial programming front end, one access per cycle
// Notes:   settings reach the pads two edges after a write
//
// Contract
// - pair five edge rate code selects 2.75, 2, 1.25 or 0.7 V/ns; 00 default.
// - pair five stopped: 0x floats (default), 10 parks low, 11 parks high.
// - pair five standard: 00 lvttl default, 01 lvds, 10 lvpecl, 11 reserved.
// - pair five divider holds one value per set; default divide value is 2.
// - each divider keeps two stored sets, chosen in multi config mode.
// - output six invert bit: 0 non-inverted default, 1 inverted.
// - output six edge rate code selects 2.75, 2, 1.25 or 0.7 V/ns.
// - output six stopped: 0x floats (default), 10 drives low, 11 high.
// - output six divider holds one value per set; default value is 2.
// - divide mode 00 stops the divider and so the output.
`default_nettype none
module cobc_bank (
  input  wire logic            clk_i,
  input  wire logic            sys_rst_i,
  input  wire logic            wr_en_i,
  input  wire logic            rd_en_i,
  input  wire logic [7:0]      addr_i,
  input  wire logic [7:0]      wdata_i,
  output logic [7:0]           rdata_o,
  input  wire logic            multi_config_mode_i,
  input  wire logic            setting_set_one_i,
  input  wire logic            pair_five_enable_bit_i,
  input  wire logic            out_six_enable_bit_i,
  input  wire logic            shutdown_oe_pin_i,
  output cobc_pkg::cobc_out_t  pair_five_cfg_o,
  output cobc_pkg::cobc_out_t  out_six_cfg_o
);
  localparam logic [7:0] RST_TABLE [cobc_pkg::COBC_NUM_REGS] = '{
    cobc_pkg::COBC_RST_OUTPUT_PAIR_FIVE_CONTROL, cobc_pkg::COBC_RST_LOWMODE,
    cobc_pkg::COBC_RST_HIGH,         cobc_pkg::COBC_RST_HIGH,
    cobc_pkg::COBC_RST_OUTPUT_SIX_CONTROL, cobc_pkg::COBC_RST_LOWMODE,
    cobc_pkg::COBC_RST_HIGH,         cobc_pkg::COBC_RST_HIGH};

  logic [7:0] bank_reg [cobc_pkg::COBC_NUM_REGS];
  logic       hit;
  logic [2:0] index;
  logic       use_set_one;

  assign hit         = (addr_i >= cobc_pkg::COBC_OFS_BASE) && (addr_i <= cobc_pkg::COBC_OFS_LAST);
  assign index       = 3'(addr_i - cobc_pkg::COBC_OFS_BASE);
  // outside multi config mode the device runs from set zero only
  assign use_set_one = multi_config_mode_i & setting_set_one_i;

  // reserved bits are stored as written; keeping them is up to software
  genvar g;
  generate
    for (g = 0; g < cobc_pkg::COBC_NUM_REGS; g++) begin : g_reg
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          bank_reg[g] <= RST_TABLE[g];
        end else if (wr_en_i && hit && (index == 3'(g))) begin
          bank_reg[g] <= wdata_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= cobc_pkg::COBC_RST_UNMAPPED;
    end else if (rd_en_i) begin
      rdata_o <= hit ? bank_reg[index] : cobc_pkg::COBC_RST_UNMAPPED;
    end
  end

  cobc_out_decode #(
    .HAS_IO_STD (1'b1),
    .HAS_INVERT (1'b0)
  ) u_pair_five (
    .clk_i             (clk_i),
    .sys_rst_i         (sys_rst_i),
    .ctrl_i            (bank_reg[cobc_pkg::COBC_IX_CTRL]),
    .lowmode_i         (bank_reg[cobc_pkg::COBC_IX_LOW]),
    .high0_i           (bank_reg[cobc_pkg::COBC_IX_HIGH0]),
    .high1_i           (bank_reg[cobc_pkg::COBC_IX_HIGH1]),
    .use_set_one_i     (use_set_one),
    .enable_bit_i      (pair_five_enable_bit_i),
    .shutdown_oe_pin_i (shutdown_oe_pin_i),
    .cfg_o             (pair_five_cfg_o)
  );

  cobc_out_decode #(
    .HAS_IO_STD (1'b0),
    .HAS_INVERT (1'b1)
  ) u_out_six (
    .clk_i             (clk_i),
    .sys_rst_i         (sys_rst_i),
    .ctrl_i            (bank_reg[cobc_pkg::COBC_IX_OUTPUT_SIX + cobc_pkg::COBC_IX_CTRL]),
    .lowmode_i         (bank_reg[cobc_pkg::COBC_IX_OUTPUT_SIX + cobc_pkg::COBC_IX_LOW]),
    .high0_i           (bank_reg[cobc_pkg::COBC_IX_OUTPUT_SIX + cobc_pkg::COBC_IX_HIGH0]),
    .high1_i           (bank_reg[cobc_pkg::COBC_IX_OUTPUT_SIX + cobc_pkg::COBC_IX_HIGH1]),
    .use_set_one_i     (use_set_one),
    .enable_bit_i      (out_six_enable_bit_i),
    .shutdown_oe_pin_i (shutdown_oe_pin_i),
    .cfg_o             (out_six_cfg_o)
  );

  // helper views for the checks below
  logic [7:0] c5;
  logic [7:0] l5;
  logic [7:0] c6;
  logic [7:0] l6;
  logic [9:0] div5_set0;
  logic [9:0] div6_set0;
  logic [9:0] div5_set1;
  logic [9:0] div6_set1;
  logic [1:0] off5;
  logic [1:0] std5;
  logic [1:0] mode5_set0;
  logic [1:0] off6;
  logic [1:0] edge6;
  logic       out_six_invert;
  logic [1:0] mode6_set0;
  logic [1:0] edge_wdata;
  assign c5         = bank_reg[cobc_pkg::COBC_IX_CTRL];
  assign l5         = bank_reg[cobc_pkg::COBC_IX_LOW];
  assign c6         = bank_reg[cobc_pkg::COBC_IX_OUTPUT_SIX + cobc_pkg::COBC_IX_CTRL];
  assign l6         = bank_reg[cobc_pkg::COBC_IX_OUTPUT_SIX + cobc_pkg::COBC_IX_LOW];
  assign div5_set0  = {bank_reg[cobc_pkg::COBC_IX_HIGH0],
                       l5[cobc_pkg::COBC_F_DIV0_HI:cobc_pkg::COBC_F_DIV0_LO]};
  assign div6_set0  = {bank_reg[cobc_pkg::COBC_IX_OUTPUT_SIX + cobc_pkg::COBC_IX_HIGH0],
                       l6[cobc_pkg::COBC_F_DIV0_HI:cobc_pkg::COBC_F_DIV0_LO]};
  assign div5_set1  = {bank_reg[cobc_pkg::COBC_IX_HIGH1],
                       l5[cobc_pkg::COBC_F_DIV1_HI:cobc_pkg::COBC_F_DIV1_LO]};
  assign div6_set1  = {bank_reg[cobc_pkg::COBC_IX_OUTPUT_SIX + cobc_pkg::COBC_IX_HIGH1],
                       l6[cobc_pkg::COBC_F_DIV1_HI:cobc_pkg::COBC_F_DIV1_LO]};
  assign off5       = c5[cobc_pkg::COBC_F_OFF_HI:cobc_pkg::COBC_F_OFF_LO];
  assign std5       = c5[cobc_pkg::COBC_F_IOSTD_HI:cobc_pkg::COBC_F_IOSTD_LO];
  assign mode5_set0 = l5[cobc_pkg::COBC_F_MODE0_HI:cobc_pkg::COBC_F_MODE0_LO];
  assign off6       = c6[cobc_pkg::COBC_F_OFF_HI:cobc_pkg::COBC_F_OFF_LO];
  assign edge6      = c6[cobc_pkg::COBC_F_EDGE_HI:cobc_pkg::COBC_F_EDGE_LO];
  assign out_six_invert       = c6[cobc_pkg::COBC_F_INVERT];
  assign mode6_set0 = l6[cobc_pkg::COBC_F_MODE0_HI:cobc_pkg::COBC_F_MODE0_LO];
  assign edge_wdata = wdata_i[cobc_pkg::COBC_F_EDGE_HI:cobc_pkg::COBC_F_EDGE_LO];

  property p_edge5;
    @(posedge clk_i) disable iff (sys_rst_i)
      wr_en_i && addr_i == cobc_pkg::COBC_OFS_OUTPUT_PAIR_FIVE_CONTROL |-> ##2
        pair_five_cfg_o.edge_rate == $past(edge_wdata, 2);
  endproperty
  a_edge5: assert property (p_edge5) else $error("pair five edge rate not applied");

  property p_park5;
    @(posedge clk_i) disable iff (sys_rst_i)
      !pair_five_enable_bit_i && off5 == cobc_pkg::COBC_OFF_PARK_HIGH |=>
        pair_five_cfg_o.drive_en && pair_five_cfg_o.drive_level;
  endproperty
  a_park5: assert property (p_park5) else $error("pair five not parked high");

  property p_iostd5;
    @(posedge clk_i) disable iff (sys_rst_i)
      1'b1 |=> pair_five_cfg_o.io_std == $past(std5);
  endproperty
  a_iostd5: assert property (p_iostd5) else $error("pair five io standard wrong");

  property p_div_default;
    @(posedge clk_i) $fell(sys_rst_i) |->
      div5_set0 == cobc_pkg::COBC_DIV_DEFAULT && div6_set0 == cobc_pkg::COBC_DIV_DEFAULT;
  endproperty
  a_div_default: assert property (p_div_default) else $error("divider default not 2");

  property p_set_one;
    @(posedge clk_i) disable iff (sys_rst_i)
      multi_config_mode_i && setting_set_one_i |=>
        pair_five_cfg_o.div_value ==
          $past(div5_set1);
  endproperty
  a_set_one: assert property (p_set_one) else $error("set one divider not selected");

  property p_invert6;
    @(posedge clk_i) disable iff (sys_rst_i)
      $changed(out_six_invert) |=> out_six_cfg_o.invert == $past(out_six_invert) && !pair_five_cfg_o.invert;
  endproperty
  a_invert6: assert property (p_invert6) else $error("output six invert wrong");

  property p_edge6;
    @(posedge clk_i) disable iff (sys_rst_i)
      ##1 out_six_cfg_o.edge_rate == $past(edge6);
  endproperty
  a_edge6: assert property (p_edge6) else $error("output six edge rate wrong");

  property p_float6;
    @(posedge clk_i) disable iff (sys_rst_i)
      !shutdown_oe_pin_i && off6 != cobc_pkg::COBC_OFF_PARK_LOW &&
      off6 != cobc_pkg::COBC_OFF_PARK_HIGH |=> !out_six_cfg_o.drive_en;
  endproperty
  a_float6: assert property (p_float6) else $error("output six not floating");

  property p_mode_off;
    @(posedge clk_i) disable iff (sys_rst_i)
      !use_set_one && mode6_set0 == cobc_pkg::COBC_MODE_DISABLED |=>
        !out_six_cfg_o.divider_on && !out_six_cfg_o.running;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("disabled divider still running");

  property p_park_low6;
    @(posedge clk_i) disable iff (sys_rst_i)
      !out_six_enable_bit_i && off6 == cobc_pkg::COBC_OFF_PARK_LOW |=>
        out_six_cfg_o.drive_en && !out_six_cfg_o.drive_level;
  endproperty
  a_park_low6: assert property (p_park_low6) else $error("output six not driven low");

  property p_mode_off5;
    @(posedge clk_i) disable iff (sys_rst_i)
      !use_set_one && mode5_set0 == cobc_pkg::COBC_MODE_DISABLED |=>
        !pair_five_cfg_o.divider_on && !pair_five_cfg_o.running;
  endproperty
  a_mode_off5: assert property (p_mode_off5) else $error("pair five still running");

  property p_set_zero;
    @(posedge clk_i) disable iff (sys_rst_i)
      !use_set_one |=> pair_five_cfg_o.div_value == $past(div5_set0) &&
        out_six_cfg_o.div_value == $past(div6_set0);
  endproperty
  a_set_zero: assert property (p_set_zero) else $error("set zero divider not selected");

  property p_set_one6;
    @(posedge clk_i) disable iff (sys_rst_i)
      use_set_one |=> out_six_cfg_o.div_value == $past(div6_set1);
  endproperty
  a_set_one6: assert property (p_set_one6) else $error("output six set one divider wrong");

  c_write_read: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_en_i && hit ##1 rd_en_i && hit);
  c_park_low:   cover property (@(posedge clk_i) disable iff (sys_rst_i)
    out_six_cfg_o.drive_en && !out_six_cfg_o.running && !out_six_cfg_o.drive_level);
  c_set_switch: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(use_set_one) ##2 pair_five_cfg_o.running);
  c_invert6:    cover property (@(posedge clk_i) disable iff (sys_rst_i)
    out_six_cfg_o.invert && out_six_cfg_o.running);
  c_lvds5:      cover property (@(posedge clk_i) disable iff (sys_rst_i)
    pair_five_cfg_o.io_std == cobc_pkg::COBC_IOSTD_LVDS && pair_five_cfg_o.running);
endmodule
`default_nettype wire

/* File: tb/cobc_bank_tb_top.sv */
// Purpose: self-checking bench for the clock output bank register block
// Assumes: byte strobe port; struct outputs follow a write two edges later
// Notes:   expectations come from a shadow copy of the bank and the decode function
`default_nettype none
module cobc_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk_i     = 1'b0;
  logic                sys_rst_i = 1'b1;
  logic                wr_en_i   = 1'b0;
  logic                rd_en_i   = 1'b0;
  logic [7:0]          addr_i    = 8'h00;
  logic [7:0]          wdata_i   = 8'h00;
  logic [7:0]          rdata_o;
  logic [4:0]          lvl       = 5'h00;  // pin, en6, en5, set one, multi
  cobc_pkg::cobc_out_t pair_five_cfg_o;
  cobc_pkg::cobc_out_t out_six_cfg_o;
  logic [7:0]          shadow [8] = '{8'h0C, 8'hBB, 8'h00, 8'h00, 8'h03, 8'hBB, 8'h00, 8'h00};
  int                  fail_count = 0;
  int                  samples_checked = 0;

  always #20 clk_i = ~clk_i;

  cobc_bank u_cobc_bank (
    .clk_i                  (clk_i),
    .sys_rst_i              (sys_rst_i),
    .wr_en_i                (wr_en_i),
    .rd_en_i                (rd_en_i),
    .addr_i                 (addr_i),
    .wdata_i                (wdata_i),
    .rdata_o                (rdata_o),
    .multi_config_mode_i    (lvl[0]),
    .setting_set_one_i      (lvl[1]),
    .pair_five_enable_bit_i (lvl[2]),
    .out_six_enable_bit_i   (lvl[3]),
    .shutdown_oe_pin_i      (lvl[4]),
    .pair_five_cfg_o        (pair_five_cfg_o),
    .out_six_cfg_o          (out_six_cfg_o)
  );

  function automatic cobc_pkg::cobc_out_t exp_cfg(input logic [7:0] c, input logic [7:0] lo,
      input logic [7:0] h0, input logic [7:0] h1, input logic s1, input logic en,
      input logic six);
    cobc_pkg::cobc_out_t e;
    logic [1:0]          m;
    e = '0;
    m = s1 ? lo[5:4] : lo[1:0];
    e.div_mode = m;
    e.divider_on = (m != 2'h0);
    e.div_value = s1 ? {h1, lo[7:6]} : {h0, lo[3:2]};
    e.edge_rate = c[5:4];
    e.io_std = six ? 2'h0 : c[1:0];
    e.invert = six & c[2];
    e.running = e.divider_on & en & lvl[4];
    e.drive_en = e.running | c[7];
    e.drive_level = ~e.running & (c[7:6] == 2'h3);
    return e;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  function automatic bit mapped(input logic [7:0] a);
    return a >= 8'h58 && a <= 8'h5F;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
    if (mapped(a)) begin
      shadow[a[2:0]] = d;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] e;
    e = mapped(a) ? shadow[a[2:0]] : 8'h00;
    @(posedge clk_i);
    rd_en_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1;
    chk("rdata", 32'(rdata_o), 32'(e));
  endtask

  task automatic set_lvl(input logic [4:0] v);
    @(posedge clk_i);
    lvl <= v;
  endtask

  // three edges cover the two-edge write path plus the level input path
  task automatic chk_outs();
    cobc_pkg::cobc_out_t e5;
    cobc_pkg::cobc_out_t e6;
    logic                s1;
    repeat (3) @(posedge clk_i);
    #1;
    s1 = lvl[0] & lvl[1];
    e5 = exp_cfg(shadow[0], shadow[1], shadow[2], shadow[3], s1, lvl[2], 1'b0);
    e6 = exp_cfg(shadow[4], shadow[5], shadow[6], shadow[7], s1, lvl[3], 1'b1);
    chk("pair_five_cfg", 32'(pair_five_cfg_o), 32'(e5));
    chk("out_six_cfg", 32'(out_six_cfg_o), 32'(e6));
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    complete_run();
  end

  initial begin
    logic [7:0] a;
    logic [7:0] d;
    logic [4:0] v;
    void'($urandom(32'hC0E4B9CE));
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 8'h57; i <= 8'h60; i++) begin
      rd_chk(i[7:0]);
    end
    wr(8'h60, 8'hA5);
    rd_chk(8'h60);
    set_lvl(5'h1C);
    chk_outs();
    // every edge rate on output six (pair five at 00 only), stopped behaviour and standard, with the pin low and high
    for (int i = 0; i < 4; i++) begin
      d = {i[1:0], i[1:0], 4'h3};
      wr(8'h5C, d);
      d = {i[1:0], i[1:0], 2'h0, (i == 3) ? 2'h2 : i[1:0]};
      wr(8'h58, (d[1:0] != 2'h0) ? {d[7:6], 2'h0, d[3:0]} : d);
      for (int p = 0; p < 2; p++) begin
        set_lvl({p[0], 4'hC});
        chk_outs();
      end
    end
    // random bytes into the bank, software-side constraints kept
    for (int n = 0; n < 120; n++) begin
      a = 8'h58 + 8'($urandom % 8);
      d = 8'($urandom);
      if (a == 8'h5C) begin
        d = {d[7:4], 1'b0, d[2], 2'h3};
      end
      if (a == 8'h58 && d[1:0] == 2'h3) begin
        d[1:0] = 2'h2;
      end
      if (a == 8'h58 && d[1:0] != 2'h0) begin
        d[5:4] = 2'h0;
      end
      wr(a, d);
      rd_chk(a);
      v = 5'($urandom);
      // an enable only goes up once both sets have a live divide mode
      if (shadow[1][5:4] == 2'h0 || shadow[1][1:0] == 2'h0) begin
        v[2] = 1'b0;
      end
      if (shadow[5][5:4] == 2'h0 || shadow[5][1:0] == 2'h0) begin
        v[3] = 1'b0;
      end
      set_lvl(v);
      chk_outs();
    end
    complete_run();
  end
endmodule
`default_nettype wire
